// file: dacsp_defines.svh
`ifndef DACSP_DEFINES_SVH
`define DACSP_DEFINES_SVH

// clock periods; the master clock of the port is sys_clk
`define DACSP_SYS_NS   4
`define DACSP_XIN_NS   4

// least time in master periods rounded up to sys_clk cycles
`define DACSP_MINCYC(t) ((((t) * `DACSP_XIN_NS) + `DACSP_SYS_NS - 1) / `DACSP_SYS_NS)

// interval figures in master clock periods
`define DACSP_SCLK_DIV_XIN  10
`define DACSP_T9_XIN        13
`define DACSP_T10_XIN       11
`define DACSP_T11_MIN_XIN   8
`define DACSP_T11_MAX_XIN   10
`define DACSP_T12_NOM_XIN   4
`define DACSP_T13_MIN_XIN   4
`define DACSP_T13_MAX_XIN   6
`define DACSP_T14_XIN       41
`define DACSP_T15_XIN       22

// the same intervals as sys_clk cycle counts
`define DACSP_PER_CYC   `DACSP_MINCYC(`DACSP_SCLK_DIV_XIN)
`define DACSP_HALF_CYC  (`DACSP_PER_CYC / 2)
`define DACSP_T9_CYC    `DACSP_MINCYC(`DACSP_T9_XIN)
`define DACSP_T10_CYC   `DACSP_MINCYC(`DACSP_T10_XIN)
`define DACSP_T11_CYC   `DACSP_MINCYC(`DACSP_T11_MIN_XIN)
`define DACSP_T13_CYC   `DACSP_MINCYC(`DACSP_T13_MIN_XIN)
`define DACSP_T14_CYC   `DACSP_MINCYC(`DACSP_T14_XIN)
`define DACSP_T15_CYC   `DACSP_MINCYC(`DACSP_T15_XIN)

// edges a toggle needs to pass the three-flop synchroniser
`define DACSP_SYNC_LAT  3

// instruction byte layout
`define DACSP_INS_RD_BIT   7
`define DACSP_INS_MB_HI    6
`define DACSP_INS_MB_LO    5
`define DACSP_INS_ADDR_HI  3

// reset and idle values
`define DACSP_GAP_MAX    6'h3F
`define DACSP_LINE_IDLE  1'h1
`endif

// file: dacsp_pkg.sv
package dacsp_pkg;
  // host sequencer states
  typedef enum logic [1:0] {
    HS_IDLE,
    HS_CSLEAD,
    HS_SHIFT,
    HS_TURN
  } dacsp_hst_state_type;
endpackage

// file: dacsp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dacsp_link_if;
  logic sclk;
  logic cs_n;
  logic h_sdo;
  logic h_oe_n;
  logic d_sdo;
  logic d_oe_n;
  logic sdio;

  // shared data wire, pulled high when nobody drives
  assign sdio = !h_oe_n ? h_sdo : (!d_oe_n ? d_sdo : 1'h1);

  modport host (output sclk, output cs_n, output h_sdo, output h_oe_n, input sdio);
  modport dev  (input sclk, input cs_n, input sdio, output d_sdo, output d_oe_n);
endinterface
`default_nettype wire

// file: dacsp_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "dacsp_defines.svh"
module dacsp_dev (
  // master clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // serial link
  dacsp_link_if.dev       link,
  // register update side
  output logic            upd_valid,
  output logic [3:0]      upd_addr,
  output logic [7:0]      upd_data,
  output logic            sdio_drive
);
  logic [2:0] bit_r;
  logic [1:0] byte_r;
  logic       data_ph_r;
  logic [7:0] ins_r;
  logic [7:0] sh_r;
  logic [7:0] mem_r [16];
  logic [2:0] tgl_r;
  logic [3:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic       out_r;
  logic [3:0] cnt_r;
  logic       going_on_r;
  logic       oe_n_r;
  logic       upd_valid_r;
  logic [3:0] upd_addr_r;
  logic [7:0] upd_data_r;

  // link-side decode
  wire [7:0] sh_nxt    = {sh_r[6:0], link.sdio};
  wire       byte_done = bit_r == 3'h7;
  wire       is_rd     = ins_r[`DACSP_INS_RD_BIT];
  wire [1:0] mb        = ins_r[`DACSP_INS_MB_HI:`DACSP_INS_MB_LO];
  wire [3:0] cur_addr  = ins_r[`DACSP_INS_ADDR_HI:0] + {2'h0, byte_r};
  wire [7:0] rd_byte   = mem_r[cur_addr];
  wire       framed    = data_ph_r || !link.cs_n;
  wire       wr_byte   = framed && byte_done && data_ph_r && !is_rd;
  wire [2:0] ev;

  // bit framing on the falling edge; select only gates a new instruction
  always_ff @(negedge link.sclk or posedge srst)
  begin
    if (srst)
    begin
      bit_r     <= 3'h0;
      byte_r    <= 2'h0;
      data_ph_r <= 1'h0;
      ins_r     <= 8'h00;
      sh_r      <= 8'h00;
      tgl_r     <= 3'h0;
      wr_addr_r <= 4'h0;
      wr_data_r <= 8'h00;
    end
    else if (framed)
    begin
      sh_r  <= sh_nxt;
      bit_r <= bit_r + 3'h1;
      if (byte_done && !data_ph_r)
      begin
        ins_r     <= sh_nxt;
        data_ph_r <= 1'h1;
        byte_r    <= 2'h0;
        tgl_r[0]  <= tgl_r[0] ^ sh_nxt[`DACSP_INS_RD_BIT];
      end
      else if (byte_done)
      begin
        byte_r <= byte_r + 2'h1;
        if (!is_rd)
        begin
          wr_addr_r <= cur_addr;
          wr_data_r <= sh_nxt;
          tgl_r[2]  <= ~tgl_r[2];
        end
        if (byte_r == mb)
        begin
          data_ph_r <= 1'h0;
          tgl_r[1]  <= tgl_r[1] ^ is_rd;
        end
      end
    end
    else
    begin
      bit_r <= 3'h0;
    end
  end

  // register bytes written by the host
  always_ff @(negedge link.sclk)
  begin
    if (wr_byte)
      mem_r[cur_addr] <= sh_nxt;
  end

  // read data changes only after a rising edge
  always_ff @(posedge link.sclk or posedge srst)
  begin
    if (srst)
      out_r <= `DACSP_LINE_IDLE;
    else if (data_ph_r && is_rd)
      out_r <= rd_byte[3'h7 - bit_r];
  end

  // three-flop toggle synchronisers into the master clock domain
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      // each channel owns its flops, so no variable has two writers
      always_ff @(posedge sys_clk)
      begin
        if (srst)
        begin
          s1_r  <= 1'h0;
          s2_r  <= 1'h0;
          s3_r  <= 1'h0;
          lvl_r <= 1'h0;
        end
        else
        begin
          s1_r <= tgl_r[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            lvl_r <= s3_r;
        end
      end
      assign ev[gi] = (s2_r == s3_r) && (s3_r != lvl_r);
    end
  endgenerate

  // line turn-around timer; select plays no part in it
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cnt_r      <= 4'h0;
      going_on_r <= 1'h0;
      oe_n_r     <= 1'h1;
    end
    else if (ev[0])
    begin
      cnt_r      <= 4'(`DACSP_T11_CYC - `DACSP_SYNC_LAT);
      going_on_r <= 1'h1;
    end
    else if (ev[1])
    begin
      cnt_r      <= 4'(`DACSP_T13_CYC - `DACSP_SYNC_LAT);
      going_on_r <= 1'h0;
    end
    else if (cnt_r != 4'h0)
    begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h1)
        oe_n_r <= !going_on_r;
    end
  end

  // written bytes handed to the user side
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      upd_valid_r <= 1'h0;
      upd_addr_r  <= 4'h0;
      upd_data_r  <= 8'h00;
    end
    else
    begin
      upd_valid_r <= ev[2];
      if (ev[2])
      begin
        upd_addr_r <= wr_addr_r;
        upd_data_r <= wr_data_r;
      end
    end
  end

  // outputs
  assign link.d_sdo  = out_r;
  assign link.d_oe_n = oe_n_r;
  assign upd_valid   = upd_valid_r;
  assign upd_addr    = upd_addr_r;
  assign upd_data    = upd_data_r;
  assign sdio_drive  = !oe_n_r;
endmodule
`default_nettype wire

// file: dacsp_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "dacsp_defines.svh"
module dacsp_host (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // configuration
  input  wire logic        use_cs,
  // request side
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_read,
  input  wire logic [1:0]  req_mb,
  input  wire logic [3:0]  req_addr,
  input  wire logic [31:0] req_wdata,
  // answer side
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  // serial link
  dacsp_link_if.host       link
);
  dacsp_pkg::dacsp_hst_state_type state_r;
  logic [3:0]  cnt_r;
  logic [5:0]  wait_r;
  logic [5:0]  gap_r;
  logic [5:0]  bits_r;
  logic        data_ph_r;
  logic        rd_r;
  logic [1:0]  mb_r;
  logic [31:0] sh_r;
  logic [31:0] wd_r;
  logic [31:0] rx_r;
  logic        sclk_r;
  logic        cs_n_r;
  logic        sdo_r;
  logic        oe_n_r;
  logic        rsp_valid_r;
  logic [31:0] rsp_rdata_r;
  logic        sdi1_r;
  logic        sdi2_r;
  logic        sdi3_r;
  logic        sdi_r;

  // bit period decode
  wire half_tick = cnt_r == 4'(`DACSP_HALF_CYC - 1);
  wire per_tick  = cnt_r == 4'(`DACSP_PER_CYC - 1);
  wire in_shift  = state_r == dacsp_pkg::HS_SHIFT;
  wire in_wait   = (state_r == dacsp_pkg::HS_CSLEAD) || (state_r == dacsp_pkg::HS_TURN);

  // link events
  wire rise_go   = (in_wait && (wait_r == 6'h00)) || (in_shift && per_tick && (bits_r != 6'h00));
  wire fall_go   = in_shift && half_tick;
  wire stage_end = in_shift && per_tick && (bits_r == 6'h00);
  wire ins_end   = stage_end && !data_ph_r;
  wire frame_end = stage_end && data_ph_r;

  // gap since last falling edge of the previous frame
  wire gap_cs_ok = gap_r >= 6'(`DACSP_T15_CYC + `DACSP_HALF_CYC - 1);
  wire gap_lo_ok = gap_r >= 6'(`DACSP_T14_CYC - 2);
  wire gap_ok    = use_cs ? gap_cs_ok : gap_lo_ok;

  // request acceptance and framing words
  assign req_ready = (state_r == dacsp_pkg::HS_IDLE) && gap_ok;
  wire        take      = req_valid && req_ready;
  wire [7:0]  ins_byte  = {req_read, req_mb, 1'h0, req_addr};
  wire [5:0]  req_bits  = {1'h0, req_mb, 3'h0} + 6'h08;
  wire [5:0]  data_bits = {1'h0, mb_r, 3'h0} + 6'h08;
  wire [31:0] wdata_al  = req_wdata << (6'h20 - req_bits);

  // read data input, three flops, change taken once flops two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sdi1_r <= `DACSP_LINE_IDLE;
      sdi2_r <= `DACSP_LINE_IDLE;
      sdi3_r <= `DACSP_LINE_IDLE;
      sdi_r  <= `DACSP_LINE_IDLE;
    end
    else
    begin
      sdi1_r <= link.sdio;
      sdi2_r <= sdi1_r;
      sdi3_r <= sdi2_r;
      if (sdi2_r == sdi3_r)
        sdi_r <= sdi3_r;
    end
  end

  // sequencer: select lead, shifting, turn-around
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_r <= dacsp_pkg::HS_IDLE;
      wait_r  <= 6'h00;
    end
    else
    begin
      case (state_r)
        dacsp_pkg::HS_IDLE:
        begin
          if (take)
          begin
            state_r <= dacsp_pkg::HS_CSLEAD;
            wait_r  <= use_cs ? 6'(`DACSP_T10_CYC - 1) : 6'h00;
          end
        end
        dacsp_pkg::HS_CSLEAD, dacsp_pkg::HS_TURN:
        begin
          if (wait_r == 6'h00)
            state_r <= dacsp_pkg::HS_SHIFT;
          else
            wait_r <= wait_r - 6'h01;
        end
        dacsp_pkg::HS_SHIFT:
        begin
          if (ins_end)
          begin
            state_r <= dacsp_pkg::HS_TURN;
            wait_r  <= 6'(`DACSP_T9_CYC - `DACSP_HALF_CYC - 1);
          end
          else if (frame_end)
            state_r <= dacsp_pkg::HS_IDLE;
        end
        default:
          state_r <= dacsp_pkg::HS_IDLE;
      endcase
    end
  end

  // bit period divider and bit count
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cnt_r  <= 4'h0;
      bits_r <= 6'h00;
    end
    else
    begin
      if (rise_go)
        cnt_r <= 4'h0;
      else if (in_shift)
        cnt_r <= cnt_r + 4'h1;
      if (take)
        bits_r <= 6'h08;
      else if (ins_end)
        bits_r <= data_bits;
      else if (fall_go)
        bits_r <= bits_r - 6'h01;
    end
  end

  // frame kind and outgoing shift register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      data_ph_r <= 1'h0;
      rd_r      <= 1'h0;
      mb_r      <= 2'h0;
      sh_r      <= 32'h00000000;
      wd_r      <= 32'h00000000;
    end
    else if (take)
    begin
      data_ph_r <= 1'h0;
      rd_r      <= req_read;
      mb_r      <= req_mb;
      sh_r      <= {ins_byte, 24'h000000};
      wd_r      <= wdata_al;
    end
    else if (ins_end)
    begin
      data_ph_r <= 1'h1;
      sh_r      <= wd_r;
    end
    else if (rise_go)
      sh_r <= {sh_r[30:0], 1'h0};
  end

  // read data taken at the falling edge, half-way through the bit period
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rx_r <= 32'h00000000;
    else if (take)
      rx_r <= 32'h00000000;
    else if (fall_go && data_ph_r && rd_r)
      rx_r <= {rx_r[30:0], sdi_r};
  end

  // serial clock and data pins; data presented at the rising edge
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sclk_r <= 1'h0;
      sdo_r  <= `DACSP_LINE_IDLE;
      oe_n_r <= 1'h1;
    end
    else if (rise_go)
    begin
      sclk_r <= 1'h1;
      sdo_r  <= sh_r[31];
      oe_n_r <= data_ph_r && rd_r;
    end
    else if (fall_go)
      sclk_r <= 1'h0;
    else if (stage_end)
      oe_n_r <= 1'h1;
  end

  // chip select and inter-frame gap counter
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cs_n_r <= 1'h1;
      gap_r  <= `DACSP_GAP_MAX;
    end
    else
    begin
      if (take && use_cs)
        cs_n_r <= 1'h0;
      else if (frame_end)
        cs_n_r <= use_cs;
      else if ((state_r == dacsp_pkg::HS_IDLE) && !use_cs && gap_cs_ok)
        cs_n_r <= 1'h0;
      if (frame_end)
        gap_r <= 6'(`DACSP_HALF_CYC);
      else if (gap_r != `DACSP_GAP_MAX)
        gap_r <= gap_r + 6'h01;
    end
  end

  // answer at frame end
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rsp_valid_r <= 1'h0;
      rsp_rdata_r <= 32'h00000000;
    end
    else
    begin
      rsp_valid_r <= frame_end;
      if (frame_end)
        rsp_rdata_r <= rx_r;
    end
  end

  // outputs
  assign link.sclk   = sclk_r;
  assign link.cs_n   = cs_n_r;
  assign link.h_sdo  = sdo_r;
  assign link.h_oe_n = oe_n_r;
  assign rsp_valid   = rsp_valid_r;
  assign rsp_rdata   = rsp_rdata_r;
endmodule
`default_nettype wire

// file: dacsp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dacsp_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic h_sdo,
  input wire logic h_oe_n,
  input wire logic d_sdo,
  input wire logic d_oe_n,
  input wire logic sdio
);
  logic [5:0] low_r;
  logic [5:0] low_nxt;
  logic [5:0] csl_r;
  logic [5:0] csl_nxt;
  logic [5:0] csh_r;
  logic [5:0] csh_nxt;

  // saturating counts of clock low, select low and select high
  assign low_nxt = sclk ? 6'h00 : ((low_r == 6'h3F) ? low_r : low_r + 6'h01);
  assign csl_nxt = cs_n ? 6'h00 : ((csl_r == 6'h3F) ? csl_r : csl_r + 6'h01);
  assign csh_nxt = !cs_n ? 6'h00 : ((csh_r == 6'h3F) ? csh_r : csh_r + 6'h01);

  // counters start as if the link had been idle for long
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      low_r <= 6'h3F;
      csl_r <= 6'h00;
      csh_r <= 6'h3F;
    end
    else
    begin
      low_r <= low_nxt;
      csl_r <= csl_nxt;
      csh_r <= csh_nxt;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  // clock shape and spacing
  AST_SCLK_HIGH: assert property (
    $rose(sclk) |-> sclk [*5] ##1 !sclk) else $error("serial clock high time wrong");
  AST_SCLK_GAP: assert property (
    $rose(sclk) |-> (low_r == 6'h05) || (low_r >= 6'h0D)) else $error("serial clock low gap short");
  AST_TIED_GAP: assert property (
    $rose(sclk) && (low_r > 6'h0D) && (csl_r >= low_r) |-> low_r >= 6'h29)
    else $error("frame gap with select low too short");
  AST_CS_LEAD: assert property (
    $rose(sclk) |-> csl_r >= 6'h0B) else $error("clock too soon after select");
  AST_CS_HIGH: assert property (
    $fell(cs_n) |-> csh_r >= 6'h16) else $error("select high time too short");
  // data line changes only in the clock high phase
  AST_DEV_CHG: assert property (
    !d_oe_n && $past(!d_oe_n) && $changed(d_sdo) |-> sclk) else $error("device data moved late");
  AST_HOST_CHG: assert property (
    !h_oe_n && $past(!h_oe_n) && $changed(h_sdo) |-> sclk) else $error("host data moved late");
  // device turn-around timing
  AST_DRV_ON: assert property (
    $fell(d_oe_n) |-> (low_r >= 6'h08) && (low_r <= 6'h0A)) else $error("device drive start off");
  AST_DRV_LEAD: assert property (
    $fell(d_oe_n) |-> !sclk [*4]) else $error("device drive lead too short");
  AST_DRV_OFF: assert property (
    $rose(d_oe_n) |-> (low_r >= 6'h04) && (low_r <= 6'h06)) else $error("device release off");
  AST_NO_FIGHT: assert property (
    !d_oe_n |-> h_oe_n && sdio == d_sdo) else $error("device drives while host drives");
endmodule
`default_nettype wire

// file: tb_dac_serial_port_timing.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dac_serial_port_timing;
  // clock, reset and user sides
  logic        sys_clk;
  logic        srst;
  logic        use_cs;
  logic        req_valid;
  logic        req_ready;
  logic        req_read;
  logic [1:0]  req_mb;
  logic [3:0]  req_addr;
  logic [31:0] req_wdata;
  logic        rsp_valid;
  logic [31:0] rsp_rdata;
  logic        upd_valid;
  logic [3:0]  upd_addr;
  logic [7:0]  upd_data;
  logic        sdio_drive;
  int          fails;
  int          n_tests;
  logic [11:0] upd_q [$];

  dacsp_link_if dacsp_link_if_i ();
  dacsp_host dacsp_host_i (.sys_clk(sys_clk), .srst(srst), .use_cs(use_cs),
    .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read), .req_mb(req_mb),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .link(dacsp_link_if_i));
  dacsp_dev dacsp_dev_i (.sys_clk(sys_clk), .srst(srst), .link(dacsp_link_if_i),
    .upd_valid(upd_valid), .upd_addr(upd_addr), .upd_data(upd_data),
    .sdio_drive(sdio_drive));
  dacsp_monitor dacsp_monitor_i (.sys_clk(sys_clk), .srst(srst),
    .sclk(dacsp_link_if_i.sclk), .cs_n(dacsp_link_if_i.cs_n),
    .h_sdo(dacsp_link_if_i.h_sdo), .h_oe_n(dacsp_link_if_i.h_oe_n),
    .d_sdo(dacsp_link_if_i.d_sdo), .d_oe_n(dacsp_link_if_i.d_oe_n),
    .sdio(dacsp_link_if_i.sdio));

  // 250 MHz master clock
  always #2 sys_clk = ~sys_clk;

  // record every byte the device stores
  always @(posedge sys_clk)
  begin
    if (upd_valid === 1'h1)
      upd_q.push_back({upd_addr, upd_data});
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one host frame: hold the request until taken, then wait for its end
  task xfer(input logic rd, input logic [1:0] mb, input logic [3:0] addr,
            input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    #1;
    req_valid = 1'h1;
    req_read = rd;
    req_mb = mb;
    req_addr = addr;
    req_wdata = wd;
    n = 0;
    @(posedge sys_clk);
    while (req_ready !== 1'h1 && n < 2000)
    begin
      n++;
      @(posedge sys_clk);
    end
    #1;
    req_valid = 1'h0;
    @(posedge sys_clk);
    while (rsp_valid !== 1'h1 && n < 4000)
    begin
      n++;
      @(posedge sys_clk);
    end
    check(32'(n >= 2000), 32'h0);
  endtask

  // four bytes with select, address wrapping past the top
  task t_cs_write;
    upd_q.delete();
    xfer(1'h0, 2'h3, 4'hE, 32'hA1B2C3D4);
    repeat (8) @(posedge sys_clk);
    check(32'(upd_q.size()), 32'h4);
    for (int i = 0; i < 4; i++)
      check({20'h0, upd_q[i]}, {20'h0, 4'(4'hE + i), 8'(32'hA1B2C3D4 >> (24 - 8 * i))});
    check(rsp_rdata, 32'h0);
    check({31'h0, dacsp_link_if_i.d_oe_n}, 32'h1);
  endtask

  // read the same bytes back, then the line must be released
  task t_cs_read;
    xfer(1'h1, 2'h3, 4'hE, 32'h0);
    check(rsp_rdata, 32'hA1B2C3D4);
    repeat (8) @(posedge sys_clk);
    check({31'h0, dacsp_link_if_i.d_oe_n}, 32'h1);
    check({31'h0, dacsp_link_if_i.sdio}, 32'h1);
    check({31'h0, sdio_drive}, 32'h0);
  endtask

  // select held low: back-to-back frames framed by count alone
  task t_tied;
    @(posedge sys_clk);
    #1;
    use_cs = 1'h0;
    repeat (40) @(posedge sys_clk);
    xfer(1'h0, 2'h0, 4'h5, 32'h5A);
    xfer(1'h1, 2'h0, 4'h5, 32'h0);
    check(rsp_rdata, 32'h5A);
    xfer(1'h1, 2'h1, 4'hF, 32'h0);
    check(rsp_rdata, 32'hB2C3);
    check({31'h0, dacsp_link_if_i.cs_n}, 32'h0);
  endtask

  // main sequence
  initial
  begin
    sys_clk = 1'h0;
    srst = 1'h1;
    use_cs = 1'h1;
    req_valid = 1'h0;
    req_read = 1'h0;
    req_mb = 2'h0;
    req_addr = 4'h0;
    req_wdata = 32'h0;
    fails = 0;
    n_tests = 0;
    repeat (20) @(posedge sys_clk);
    #1;
    srst = 1'h0;
    t_cs_write();
    t_cs_read();
    t_tied();
    wrap_up();
  end

  // watchdog, well past the expected run of about 2000 cycles
  initial
  begin
    #40000;
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
